// ### rtl/ptra_pkg.sv
// package: register map, field layout and carriers for the template ram access block
package ptra_pkg;
  localparam int ADDR_W = 8;
  localparam int AMP_W = 7;
  localparam int GAIN_W = 6;
  localparam int IVL_W = 2;
  localparam int SLOT_W = 4;
  localparam int RAM_AW = IVL_W + SLOT_W;
  localparam int RAM_DEPTH = 64;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_GAIN = 8'h24;
  localparam logic [7:0] IDX_CTRL = 8'h25;
  localparam logic [7:0] IDX_DATA = 8'h26;
  localparam logic [ADDR_W-1:0] ADDR_GAIN = ADDR_W'({IDX_GAIN, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_CTRL = ADDR_W'({IDX_CTRL, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_DATA = ADDR_W'({IDX_DATA, 2'b00});
  // control, data and gain register fields
  localparam int CTRL_TRIG_BIT = 7;
  localparam int CTRL_DIR_BIT = 6;
  localparam int CTRL_IVL_LSB = 4;
  localparam int CTRL_SLOT_LSB = 0;
  localparam int DATA_AMP_LSB = 0;
  localparam int GAIN_LSB = 0;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [AMP_W-1:0] DATA_RESET = 7'h00;
  localparam logic [GAIN_W-1:0] GAIN_RESET = 6'h21;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RUN = 3'h2,
    ST_LOAD = 3'h4
  } ptra_state_t;

  typedef struct packed {
    logic we;
    logic [RAM_AW-1:0] addr;
    logic [AMP_W-1:0] wdata;
  } ptra_ram_req_t;
endpackage

// ### rtl/ptra_template_ram.sv
// template ram with access port and scaled transmit read port
module ptra_template_ram #(
  parameter int DEPTH = ptra_pkg::RAM_DEPTH
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input ptra_pkg::ptra_ram_req_t acc_req,
  input wire logic acc_en,
  output logic [ptra_pkg::AMP_W-1:0] acc_rdata,
  input wire logic [ptra_pkg::RAM_AW-1:0] tx_addr,
  input wire logic [ptra_pkg::GAIN_W-1:0] gain,
  output logic [ptra_pkg::AMP_W+ptra_pkg::GAIN_W-1:0] tx_ampl
);
  logic [ptra_pkg::AMP_W-1:0] mem [DEPTH];
  logic [ptra_pkg::AMP_W-1:0] tx_sample;

  always_ff @(posedge REF_CLK) begin
    if (acc_en && acc_req.we) begin
      mem[acc_req.addr] <= acc_req.wdata;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      acc_rdata <= '0;
    end else if (acc_en && !acc_req.we) begin
      acc_rdata <= mem[acc_req.addr];
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tx_sample <= '0;
    end else begin
      tx_sample <= mem[tx_addr];
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tx_ampl <= '0;
    end else begin
      tx_ampl <= 13'(tx_sample * gain);
    end
  end
endmodule

// ### rtl/ptra_access.sv
// axi4-lite register bank with indirect access to the pulse template ram
// Function
// - writing one to control bit 7 starts one indirect ram access.
// - control bit 6 selects write (0) or read (1).
// - control bits 5-4 pick one of four unit intervals.
// - control bits 3-0 pick one of 16 samples in the interval.
// - a write stores data bits 6-0 into the addressed ram entry.
// - a finished read puts the stored amplitude into data bits 6-0.
// - transmitted samples are scaled by a 6-bit gain, reset 100001.
module ptra_access #(
  parameter int ADDR_W = ptra_pkg::ADDR_W
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [ptra_pkg::RAM_AW-1:0] TX_SLOT_ADDR,
  output logic [ptra_pkg::AMP_W+ptra_pkg::GAIN_W-1:0] TX_AMPLITUDE,
  output logic ACCESS_BUSY
);
  logic [ADDR_W-1:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic wr_fire;
  logic [7:0] ctrl;
  logic [ptra_pkg::AMP_W-1:0] template_amplitude;
  logic [ptra_pkg::GAIN_W-1:0] pulse_gain_factor;
  ptra_pkg::ptra_state_t state;
  ptra_pkg::ptra_state_t next_state;
  ptra_pkg::ptra_ram_req_t ram_req;
  logic ram_en;
  logic [ptra_pkg::AMP_W-1:0] ram_rdata;
  logic [ptra_pkg::IVL_W-1:0] interval_addr;
  logic [ptra_pkg::SLOT_W-1:0] slot_addr;
  logic ctrl_wr;
  logic [2:0] wr_sel;

  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
    return {a == ptra_pkg::ADDR_DATA, a == ptra_pkg::ADDR_CTRL, a == ptra_pkg::ADDR_GAIN};
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return |reg_sel(a);
  endfunction

  // write channel capture
  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
  assign wr_fire = aw_held && w_held && !S_AXI_BVALID;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= ptra_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= is_mapped(aw_addr) ? ptra_pkg::RESP_OKAY : ptra_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // write enables per register, bit 0 gain, 1 control, 2 data
  assign wr_sel = (wr_fire && w_strb[0]) ? reg_sel(aw_addr) : 3'h0;
  // control writes are ignored while an access is under way
  assign ctrl_wr = wr_sel[1] && (state == ptra_pkg::ST_IDLE);

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ctrl <= ptra_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= w_data[7:0];
    end else if (next_state == ptra_pkg::ST_IDLE && state != ptra_pkg::ST_IDLE) begin
      ctrl[ptra_pkg::CTRL_TRIG_BIT] <= 1'b0;
    end
  end

  assign interval_addr = ctrl[ptra_pkg::CTRL_IVL_LSB +: ptra_pkg::IVL_W];
  assign slot_addr = ctrl[ptra_pkg::CTRL_SLOT_LSB +: ptra_pkg::SLOT_W];

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state <= ptra_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ptra_pkg::ST_IDLE: begin
        if (ctrl[ptra_pkg::CTRL_TRIG_BIT]) begin
          next_state = ptra_pkg::ST_RUN;
        end
      end
      ptra_pkg::ST_RUN: begin
        // write ends here, read loads next
        if (ctrl[ptra_pkg::CTRL_DIR_BIT]) begin
          next_state = ptra_pkg::ST_LOAD;
        end else begin
          next_state = ptra_pkg::ST_IDLE;
        end
      end
      ptra_pkg::ST_LOAD: begin
        next_state = ptra_pkg::ST_IDLE;
      end
      default: begin
        next_state = ptra_pkg::ST_IDLE;
      end
    endcase
  end

  assign ram_en = (state == ptra_pkg::ST_RUN);
  assign ram_req.we = !ctrl[ptra_pkg::CTRL_DIR_BIT];
  assign ram_req.addr = {interval_addr, slot_addr};
  assign ram_req.wdata = template_amplitude;
  assign ACCESS_BUSY = (state != ptra_pkg::ST_IDLE);

  // read result wins over a software write
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      template_amplitude <= ptra_pkg::DATA_RESET;
    end else if (state == ptra_pkg::ST_LOAD) begin
      template_amplitude <= ram_rdata;
    end else if (wr_sel[2]) begin
      template_amplitude <= w_data[ptra_pkg::DATA_AMP_LSB +: ptra_pkg::AMP_W];
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pulse_gain_factor <= ptra_pkg::GAIN_RESET;
    end else if (wr_sel[0]) begin
      pulse_gain_factor <= w_data[ptra_pkg::GAIN_LSB +: ptra_pkg::GAIN_W];
    end
  end

  // read channel
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= ptra_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= is_mapped(S_AXI_ARADDR) ? ptra_pkg::RESP_OKAY : ptra_pkg::RESP_SLVERR;
      case (S_AXI_ARADDR)
        ptra_pkg::ADDR_GAIN: S_AXI_RDATA <= {26'h0, pulse_gain_factor};
        ptra_pkg::ADDR_CTRL: S_AXI_RDATA <= {24'h0, ctrl};
        ptra_pkg::ADDR_DATA: S_AXI_RDATA <= {25'h0, template_amplitude};
        default: S_AXI_RDATA <= 32'h0;
      endcase
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  ptra_template_ram #(
    .DEPTH(ptra_pkg::RAM_DEPTH)
  ) i_ptra_template_ram (
    .REF_CLK(REF_CLK),
    .RST(RST),
    .acc_req(ram_req),
    .acc_en(ram_en),
    .acc_rdata(ram_rdata),
    .tx_addr(TX_SLOT_ADDR),
    .gain(pulse_gain_factor),
    .tx_ampl(TX_AMPLITUDE)
  );
endmodule

// ### testbench/ptra_access_sva.sv
// port assertions for the template access register bank
module ptra_access_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic ACCESS_BUSY
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  a_trig_busy: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && S_AXI_WSTRB[0]
    && S_AXI_AWADDR == ptra_pkg::ADDR_CTRL && S_AXI_WDATA[7] && !ACCESS_BUSY |-> ##3 ACCESS_BUSY)
    else $error("access did not start");
  a_busy_short: assert property (ACCESS_BUSY |-> ##[1:2] !ACCESS_BUSY)
    else $error("access too long");
  a_write_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while response pending");
  a_bresp_hold: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  a_bresp_done: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response not retired");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("no read answer");
  a_rdata_hold: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  a_rdata_done: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read data not retired");
  a_rdata_upper: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  a_read_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while data pending");
endmodule

bind ptra_access ptra_access_sva #(.ADDR_W(ADDR_W)) i_ptra_access_sva (.*);

// ### testbench/tb_top.sv
// self-checking bench for the template access register bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic REF_CLK = 0, RST = 1;
  logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
  logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0;
  logic S_AXI_RREADY = 0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, ACCESS_BUSY;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
  logic [5:0] TX_SLOT_ADDR = 0, g;
  logic [12:0] TX_AMPLITUDE;
  logic [31:0] v;
  logic [7:0] seed = 8'h3a;
  logic [6:0] mem [64];
  int n_errors = 0, n_tests = 0, cyc = 0;

  ptra_access i_ptra_access (
    .REF_CLK(REF_CLK),
    .RST(RST),
    .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB),
    .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY),
    .TX_SLOT_ADDR(TX_SLOT_ADDR),
    .TX_AMPLITUDE(TX_AMPLITUDE),
    .ACCESS_BUSY(ACCESS_BUSY)
  );

  initial forever #25 REF_CLK = ~REF_CLK;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // control value once an access has ended: trigger cleared, rest as written
  function automatic logic [31:0] ctrl_after(input logic dir, input logic [5:0] sel);
    return {24'h0, 1'b0, dir, sel};
  endfunction

  // transmit amplitude: stored sample times gain
  function automatic logic [31:0] tx_expect(input logic [6:0] s, input logic [5:0] gn);
    return 32'(s) * 32'(gn);
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge REF_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1;
    S_AXI_WVALID <= 1;
    S_AXI_BREADY <= 1;
    forever begin
      @(posedge REF_CLK);
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 0;
      if (S_AXI_BVALID) break;
    end
    rs = S_AXI_BRESP;
    S_AXI_BREADY <= 0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge REF_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1;
    S_AXI_RREADY <= 1;
    forever begin
      @(posedge REF_CLK);
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 0;
      if (S_AXI_RVALID) break;
    end
    d = S_AXI_RDATA;
    rs = S_AXI_RRESP;
    S_AXI_RREADY <= 0;
  endtask

  // polls the trigger bit until the access has ended
  task automatic pollw;
    repeat (8) begin
      rd(ptra_pkg::ADDR_CTRL, v, r);
      if (v[7] === 1'b0) break;
    end
  endtask

  task report_and_stop;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop;
    end
  end

  initial begin
    repeat (16) @(posedge REF_CLK);
    RST <= 0;
    rd(ptra_pkg::ADDR_GAIN, v, r);
    chk("gain reset", 32'h21, v);
    chk("gain rresp", 32'(ptra_pkg::RESP_OKAY), 32'(r));
    rd(ptra_pkg::ADDR_CTRL, v, r);
    chk("ctrl reset", 32'h0, v);
    rd(8'h00, v, r);
    chk("unmapped resp", 32'(ptra_pkg::RESP_SLVERR), 32'(r));
    wr(8'h04, 32'h0, r);
    chk("unmapped bresp", 32'(ptra_pkg::RESP_SLVERR), 32'(r));
    // a write with the low strobe clear must leave the register alone
    S_AXI_WSTRB <= 4'h0;
    wr(ptra_pkg::ADDR_GAIN, 32'h15, r);
    S_AXI_WSTRB <= 4'hf;
    chk("masked bresp", 32'(ptra_pkg::RESP_OKAY), 32'(r));
    rd(ptra_pkg::ADDR_GAIN, v, r);
    chk("masked gain", 32'h21, v);
    for (int i = 0; i < 64; i++) begin
      seed = lfsr(seed);
      mem[i] = (i == 0) ? 7'h7f : (i == 63) ? 7'h00 : seed[6:0];
      wr(ptra_pkg::ADDR_DATA, 32'(mem[i]), r);
      wr(ptra_pkg::ADDR_CTRL, 32'({2'b10, i[5:0]}), r);
      chk("ctrl bresp", 32'(ptra_pkg::RESP_OKAY), 32'(r));
      pollw;
      chk("write ctrl", ctrl_after(1'b0, 6'(i)), v);
    end
    for (int i = 63; i >= 0; i--) begin
      wr(ptra_pkg::ADDR_DATA, {25'h0, ~mem[i]}, r);
      wr(ptra_pkg::ADDR_CTRL, 32'({2'b11, i[5:0]}), r);
      pollw;
      chk("read ctrl", ctrl_after(1'b1, 6'(i)), v);
      rd(ptra_pkg::ADDR_DATA, v, r);
      chk("amplitude", 32'(mem[i]), v);
    end
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      g = (k == 0) ? 6'h3f : seed[5:0];
      wr(ptra_pkg::ADDR_GAIN, 32'(g), r);
      TX_SLOT_ADDR <= 6'(seed + 8'(k));
      repeat (3) @(posedge REF_CLK);
      #1;
      chk("tx amplitude", tx_expect(mem[TX_SLOT_ADDR], g), 32'(TX_AMPLITUDE));
    end
    report_and_stop;
  end
endmodule
